//--- rtl/fss_pkg.sv
// package: constants and carriers for the flags and segment-select block
package fss_pkg;

    // ================================================================
    // register map (byte addresses, one word apart)
    localparam logic [11:0] ADDR_FLAGS    = 12'h000;
    localparam logic [11:0] ADDR_IP       = 12'h004;
    localparam logic [11:0] ADDR_CTRL     = 12'h008;
    localparam logic [11:0] ADDR_STATUS   = 12'h00c;

    // ================================================================
    // flag bit positions
    localparam int B_CF   = 0;
    localparam int B_RSV1 = 1;
    localparam int B_PF   = 2;
    localparam int B_AF   = 4;
    localparam int B_ZF   = 6;
    localparam int B_SF   = 7;
    localparam int B_TF   = 8;
    localparam int B_IF   = 9;
    localparam int B_DF   = 10;
    localparam int B_OF   = 11;
    localparam int B_IO_PRIVILEGE_LEVEL = 12;
    localparam int B_NT   = 14;
    localparam int B_RF   = 16;
    localparam int B_VM   = 17;
    localparam int B_AC   = 18;
    localparam int B_ID   = 21;

    // writable bits; reserved bits forced by the fixed mask
    localparam logic [31:0] FLAGS_WMASK = 32'h0027_7fd5;
    localparam logic [31:0] FLAGS_FIXED = 32'h0000_0002;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [31:0] IP_RESET    = 32'h0000_fff0;

    // ctrl register bits
    localparam int C_PROT   = 0;
    localparam int C_AM     = 1;
    localparam int C_IDEN   = 2;
    localparam int C_CPL    = 4;

    // ================================================================
    // segment registers
    typedef enum logic [2:0] {
        FSS_SEG_ES = 3'h0,
        FSS_SEG_CS = 3'h1,
        FSS_SEG_SS = 3'h2,
        FSS_SEG_DS = 3'h3,
        FSS_SEG_FS = 3'h4,
        FSS_SEG_GS = 3'h5
    } fss_seg_t;

    // memory reference kinds
    typedef enum logic [2:0] {
        FSS_REF_CODE  = 3'h0,
        FSS_REF_PUSH  = 3'h1,
        FSS_REF_POP   = 3'h2,
        FSS_REF_SDST  = 3'h3,
        FSS_REF_DATA  = 3'h4,
        FSS_REF_STKB  = 3'h5
    } fss_ref_t;

    // alu operations
    typedef enum logic [1:0] {
        FSS_OP_ADD  = 2'h0,
        FSS_OP_SUB  = 2'h1,
        FSS_OP_LOGIC = 2'h2
    } fss_op_t;

    // retirement of one instruction
    typedef struct packed {
        logic        valid;
        logic [3:0]  length;
        logic        redirect;
        logic [31:0] target;
        logic        upd_arith;
        fss_op_t     op;
        logic [31:0] opa;
        logic [31:0] opb;
        logic        popf;
        logic        iret;
        logic        task_sw;
        logic [31:0] new_flags;
    } fss_retire_t;

    // segment select request
    typedef struct packed {
        fss_ref_t    kind;
        logic        ovr_valid;
        fss_seg_t    ovr_seg;
    } fss_segreq_t;

    // per-access checks
    typedef struct packed {
        logic        irq_ack;
        logic        step_trap;
        logic        align_fault;
        logic        io_fault;
        logic        debug_mask;
        logic        v86;
        logic        nested;
        logic        str_dec;
    } fss_status_t;

    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] ip;
        logic [7:0]  ctrl;
        logic [31:0] prdata;
        logic        rf_hold;
        logic        step_q;
    } fss_state_t;

endpackage : fss_pkg

//--- rtl/fss_seg_select.sv
// module: default and override segment selection per memory reference
`timescale 1ns/10ps
`default_nettype none
module fss_seg_select (
    // request
    input  wire fss_pkg::fss_segreq_t req,
    // selection
    output var fss_pkg::fss_seg_t     seg
);
    always_comb begin
        case (req.kind)
            fss_pkg::FSS_REF_CODE: seg = fss_pkg::FSS_SEG_CS;
            fss_pkg::FSS_REF_PUSH,
            fss_pkg::FSS_REF_POP:  seg = fss_pkg::FSS_SEG_SS;
            fss_pkg::FSS_REF_SDST: seg = fss_pkg::FSS_SEG_ES;
            fss_pkg::FSS_REF_DATA: begin
                seg = fss_pkg::FSS_SEG_DS;
                if (req.ovr_valid) begin
                    seg = req.ovr_seg;
                end
            end
            fss_pkg::FSS_REF_STKB: begin
                seg = fss_pkg::FSS_SEG_SS;
                if (req.ovr_valid) begin
                    seg = req.ovr_seg;
                end
            end
            default: seg = fss_pkg::FSS_SEG_DS;
        endcase
    end
endmodule : fss_seg_select
`default_nettype wire

//--- rtl/fss_core_state.sv
// module: instruction pointer, status flags register and segment select
// Function
// - ip advances by length unless redirected
// - code uses cs; stack ops use ss
// - string destination always uses es
// - other data defaults ds (stack-based data ss), override allowed
// - id bit writable only when enabled
// - alignment fault needs ac and am
// - vm gives v86 in protected mode; set by iret at level 0 or task switch
// - resume flag masks next debug fault
// - nt marks nested task
// - io_privilege_level gates io and if pops
// - of is carry-in xor carry-out of msb
// - df selects index decrement
// - irq serviced only with if set
// - tf traps after next instruction, clears
// - sf copies msb; zf marks zero
// - af is carry at bit three
// - pf set on even low-byte ones
// - cf is carry/borrow out of msb
`timescale 1ns/10ps
`default_nettype none
module fss_core_state (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    // retirement
    input  wire fss_pkg::fss_retire_t  retire,
    // access checks
    input  wire logic                  maskable_irq_pin,
    input  wire logic                  mem_misaligned,
    input  wire logic                  io_access,
    input  wire logic                  priv_opcode,
    input  wire logic                  debug_hit,
    // segment selection
    input  wire fss_pkg::fss_segreq_t  seg_req,
    output var fss_pkg::fss_seg_t      seg_sel,
    // state outputs
    output logic [31:0]                next_instr_pointer,
    output logic [31:0]                processor_status_flags,
    output var fss_pkg::fss_status_t   status,
    output logic                       gp_fault,
    output logic                       debug_fault
);
    // ================================================================
    // helpers
    function automatic logic parity_even(input logic [7:0] v);
        parity_even = ~^v;
    endfunction : parity_even

    function automatic logic [31:0] fix_flags(input logic [31:0] v);
        fix_flags = (v & fss_pkg::FLAGS_WMASK) | fss_pkg::FLAGS_FIXED;
    endfunction : fix_flags

    // ================================================================
    // state
    fss_pkg::fss_state_t st_q;
    fss_pkg::fss_state_t st_d;

    logic        wr_en;
    logic        rd_en;
    logic        prot;
    logic [1:0]  current_priv_level;
    logic [1:0]  io_privilege_level;
    logic [32:0] sum;
    logic [4:0]  low_sum;
    logic        c_in_msb;
    logic [31:0] res;
    logic [31:0] nf;
    logic [31:0] keep_mask;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign prot  = st_q.ctrl[fss_pkg::C_PROT];
    assign current_priv_level   = st_q.ctrl[fss_pkg::C_CPL +: 2];
    assign io_privilege_level  = st_q.flags[fss_pkg::B_IO_PRIVILEGE_LEVEL +: 2];

    // ================================================================
    // alu flag generation
    always_comb begin
        sum      = 33'h0_0000_0000;
        low_sum  = 5'h00;
        c_in_msb = 1'b0;
        case (retire.op)
            fss_pkg::FSS_OP_ADD: begin
                sum      = {1'b0, retire.opa} + {1'b0, retire.opb};
                low_sum  = {1'b0, retire.opa[3:0]} + {1'b0, retire.opb[3:0]};
                c_in_msb = retire.opa[31] ^ retire.opb[31] ^ sum[31];
            end
            fss_pkg::FSS_OP_SUB: begin
                sum      = {1'b0, retire.opa} - {1'b0, retire.opb};
                low_sum  = {1'b0, retire.opa[3:0]} - {1'b0, retire.opb[3:0]};
                c_in_msb = retire.opa[31] ^ retire.opb[31] ^ sum[31];
            end
            default: begin
                sum = {1'b0, retire.opa};
            end
        endcase
        res = sum[31:0];
    end

    // ================================================================
    // next state
    always_comb begin
        st_d      = st_q;
        nf        = st_q.flags;
        keep_mask = 32'h0000_0000;
        st_d.step_q = 1'b0;

        if (retire.valid) begin
            if (retire.redirect) begin
                st_d.ip = retire.target;
            end else begin
                st_d.ip = st_q.ip + {28'h000_0000, retire.length};
            end
            st_d.rf_hold = 1'b0;
            nf[fss_pkg::B_RF] = 1'b0;
            if (st_q.flags[fss_pkg::B_TF]) begin
                st_d.step_q = 1'b1;
                nf[fss_pkg::B_TF] = 1'b0;
            end
            if (retire.upd_arith) begin
                nf[fss_pkg::B_CF] = (retire.op == fss_pkg::FSS_OP_LOGIC) ? 1'b0
                                    : sum[32];
                nf[fss_pkg::B_OF] = (retire.op == fss_pkg::FSS_OP_LOGIC) ? 1'b0
                                    : (c_in_msb ^ sum[32]);
                nf[fss_pkg::B_AF] = low_sum[4];
                nf[fss_pkg::B_SF] = res[31];
                nf[fss_pkg::B_ZF] = (res == 32'h0000_0000);
                nf[fss_pkg::B_PF] = parity_even(res[7:0]);
            end
            if (retire.popf || retire.iret || retire.task_sw) begin
                keep_mask = 32'h0000_0000;
                // on popf in protected mode, if bit only changes when cpl within io_privilege_level
                if (retire.popf && prot && (current_priv_level > io_privilege_level)) begin
                    keep_mask[fss_pkg::B_IF] = 1'b1;
                end
                // vm only from iret at level 0 or task switch
                if (!(retire.task_sw || (retire.iret && current_priv_level == 2'h0))) begin
                    keep_mask[fss_pkg::B_VM] = 1'b1;
                end
                if (!st_q.ctrl[fss_pkg::C_IDEN]) begin
                    keep_mask[fss_pkg::B_ID] = 1'b1;
                end
                nf = (retire.new_flags & ~keep_mask) | (st_q.flags & keep_mask);
            end
        end

        // software write over apb
        if (wr_en) begin
            case (paddr)
                fss_pkg::ADDR_FLAGS: begin
                    keep_mask = 32'h0000_0000;
                    keep_mask[fss_pkg::B_VM] = 1'b1;
                    if (!st_q.ctrl[fss_pkg::C_IDEN]) begin
                        keep_mask[fss_pkg::B_ID] = 1'b1;
                    end
                    nf = (pwdata & ~keep_mask) | (st_q.flags & keep_mask);
                    st_d.rf_hold = pwdata[fss_pkg::B_RF];
                end
                fss_pkg::ADDR_IP:   st_d.ip   = pwdata;
                fss_pkg::ADDR_CTRL: st_d.ctrl = pwdata[7:0];
                default: ;
            endcase
        end

        st_d.flags = fix_flags(nf);

        // read data captured in setup phase
        if (rd_en) begin
            case (paddr)
                fss_pkg::ADDR_FLAGS:  st_d.prdata = st_q.flags;
                fss_pkg::ADDR_IP:     st_d.prdata = st_q.ip;
                fss_pkg::ADDR_CTRL:   st_d.prdata = {24'h00_0000, st_q.ctrl};
                fss_pkg::ADDR_STATUS: st_d.prdata = {24'h00_0000, status};
                default:              st_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ================================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.flags   <= fss_pkg::FLAGS_RESET;
            st_q.ip      <= fss_pkg::IP_RESET;
            st_q.ctrl    <= 8'h00;
            st_q.prdata  <= 32'h0000_0000;
            st_q.rf_hold <= 1'b0;
            st_q.step_q  <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ================================================================
    // apb answers
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~((paddr == fss_pkg::ADDR_FLAGS)
                     | (paddr == fss_pkg::ADDR_IP) | (paddr == fss_pkg::ADDR_CTRL)
                     | (paddr == fss_pkg::ADDR_STATUS));
    assign prdata  = st_q.prdata;

    // ================================================================
    // segment selection
    fss_seg_select u_seg (
        .req (seg_req),
        .seg (seg_sel)
    );

    // ================================================================
    // outputs
    assign next_instr_pointer     = st_q.ip;
    assign processor_status_flags = st_q.flags;

    always_comb begin
        status.irq_ack     = maskable_irq_pin & st_q.flags[fss_pkg::B_IF];
        status.step_trap   = st_q.step_q;
        status.align_fault = mem_misaligned & st_q.flags[fss_pkg::B_AC]
                             & st_q.ctrl[fss_pkg::C_AM];
        status.io_fault    = io_access & prot & (current_priv_level > io_privilege_level);
        status.debug_mask  = st_q.flags[fss_pkg::B_RF] | st_q.rf_hold;
        status.v86         = prot & st_q.flags[fss_pkg::B_VM];
        status.nested      = prot & st_q.flags[fss_pkg::B_NT];
        status.str_dec     = st_q.flags[fss_pkg::B_DF];
    end

    assign gp_fault    = (status.v86 & priv_opcode) | status.io_fault;
    assign debug_fault = debug_hit & ~status.debug_mask;

endmodule : fss_core_state
`default_nettype wire

//--- sim/fss_state_props.sv
// checker: concurrent properties on the core state ports
`timescale 1ns/10ps
`default_nettype none
module fss_state_props (
    // clock, reset and bus
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    // core side
    input wire fss_pkg::fss_retire_t retire,
    input wire logic                 maskable_irq_pin,
    input wire fss_pkg::fss_segreq_t seg_req,
    input wire fss_pkg::fss_seg_t    seg_sel,
    input wire logic [31:0]          next_instr_pointer,
    input wire logic [31:0]          processor_status_flags,
    input wire fss_pkg::fss_status_t status
);
    logic        wr;
    logic [31:0] fl;
    assign wr = psel && penable && pwrite;
    assign fl = processor_status_flags;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ================================================================
    // properties
    property p_ip;
        retire.valid && !retire.redirect && !(wr && paddr == fss_pkg::ADDR_IP)
            |=> next_instr_pointer == $past(next_instr_pointer) + 32'($past(retire.length));
    endproperty
    a_ip: assert property (p_ip) else $error("pointer step wrong");
    property p_code;
        seg_req.kind == fss_pkg::FSS_REF_CODE |-> seg_sel == fss_pkg::FSS_SEG_CS;
    endproperty
    a_code: assert property (p_code) else $error("code segment wrong");
    property p_stk;
        seg_req.kind inside {fss_pkg::FSS_REF_PUSH, fss_pkg::FSS_REF_POP}
            |-> seg_sel == fss_pkg::FSS_SEG_SS;
    endproperty
    a_stk: assert property (p_stk) else $error("stack segment wrong");
    property p_dst;
        seg_req.kind == fss_pkg::FSS_REF_SDST |-> seg_sel == fss_pkg::FSS_SEG_ES;
    endproperty
    a_dst: assert property (p_dst) else $error("string target segment wrong");
    property p_data;
        seg_req.kind == fss_pkg::FSS_REF_DATA
            |-> seg_sel == (seg_req.ovr_valid ? seg_req.ovr_seg : fss_pkg::FSS_SEG_DS);
    endproperty
    a_data: assert property (p_data) else $error("data segment wrong");
    property p_rsv;
        (fl & ~fss_pkg::FLAGS_WMASK) == fss_pkg::FLAGS_FIXED;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag bits wrong");
    property p_irq;
        status.irq_ack == (maskable_irq_pin && fl[9]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq ack wrong");
    property p_trap;
        retire.valid && fl[8] |=> status.step_trap;
    endproperty
    a_trap: assert property (p_trap) else $error("no step trap");
    property p_vm;
        wr && paddr == fss_pkg::ADDR_FLAGS && !retire.valid |=> $stable(fl[17]);
    endproperty
    a_vm: assert property (p_vm) else $error("mode bit written");
    c_trap: cover property (status.step_trap);
    c_ovr: cover property (seg_req.ovr_valid && seg_req.kind == fss_pkg::FSS_REF_DATA);
    c_jump: cover property (retire.valid && retire.redirect);
endmodule : fss_state_props
bind fss_core_state fss_state_props u_props (.*);
`default_nettype wire

//--- sim/tb_top.sv
// testbench: arithmetic rows, register, trap and segment checks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct {
        fss_pkg::fss_op_t op;
        logic [31:0]      a;
        logic [31:0]      b;
        logic [3:0]       len;
        logic [31:0]      fl;
        logic [31:0]      m;
    } fss_row_t;
    fss_row_t rows [7] = '{
        '{fss_pkg::FSS_OP_ADD, 32'hffffffff, 32'h1, 4'h1, 32'h55, 32'h8d5},
        '{fss_pkg::FSS_OP_ADD, 32'h7fffffff, 32'h1, 4'hf, 32'h894, 32'h8d5},
        '{fss_pkg::FSS_OP_SUB, 32'h0, 32'h1, 4'h2, 32'h95, 32'h8d5},
        '{fss_pkg::FSS_OP_LOGIC, 32'h0, 32'h0, 4'h3, 32'h44, 32'h8c5},
        '{fss_pkg::FSS_OP_SUB, 32'h80000000, 32'h1, 4'h4, 32'h814, 32'h8d5},
        '{fss_pkg::FSS_OP_ADD, 32'hf, 32'h1, 4'h5, 32'h10, 32'h8d5},
        '{fss_pkg::FSS_OP_ADD, 32'h3, 32'h0, 4'h6, 32'h4, 32'h8d5}};
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = '0;
    logic [31:0]          pwdata = '0;
    fss_pkg::fss_retire_t retire = '0;
    logic                 maskable_irq_pin = 1'b0;
    logic                 mem_misaligned = 1'b0;
    logic                 io_access = 1'b0;
    logic                 priv_opcode = 1'b0;
    logic                 debug_hit = 1'b0;
    fss_pkg::fss_segreq_t seg_req = '0;
    logic                 pready, pslverr, gp_fault, debug_fault, er, seen;
    logic [31:0]          prdata, next_instr_pointer, processor_status_flags, rd, ip0;
    fss_pkg::fss_seg_t    seg_sel, e;
    fss_pkg::fss_status_t status;
    fss_pkg::fss_retire_t rv;
    int                   err_count = 0;
    int                   num_checks = 0;
    fss_core_state u_dut (.*);
    initial begin
        forever #4 pclk = ~pclk;
    end
    // ================================================================
    // tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task ret(input fss_pkg::fss_retire_t r);
        @(posedge pclk);
        retire <= r;
        @(posedge pclk);
        retire.valid <= 1'b0;
        #1;
    endtask : ret
    // ================================================================
    // sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            ip0 = next_instr_pointer;
            rv = '0;
            rv.valid = 1'b1;
            rv.length = rows[i].len;
            rv.upd_arith = 1'b1;
            rv.op = rows[i].op;
            rv.opa = rows[i].a;
            rv.opb = rows[i].b;
            ret(rv);
            chk(processor_status_flags & rows[i].m, rows[i].fl);
            chk(next_instr_pointer, ip0 + 32'(rows[i].len));
        end
        $display("end of arithmetic rows");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, fss_pkg::ADDR_FLAGS, '0);
        chk(rd, 32'h2);
        maskable_irq_pin <= 1'b1;
        mem_misaligned <= 1'b1;
        debug_hit <= 1'b1;
        apb(1'b1, fss_pkg::ADDR_FLAGS, 32'hffffffff);
        apb(1'b0, fss_pkg::ADDR_FLAGS, '0);
        chk(rd, 32'h57fd7);
        chk(32'({status.irq_ack, status.str_dec, status.align_fault, debug_fault}), 32'hc);
        apb(1'b1, fss_pkg::ADDR_CTRL, 32'h6);
        apb(1'b1, fss_pkg::ADDR_FLAGS, 32'h240000);
        apb(1'b0, fss_pkg::ADDR_FLAGS, '0);
        chk(rd, 32'h240002);
        chk(32'({status.irq_ack, status.str_dec, status.align_fault}), 32'h1);
        apb(1'b1, fss_pkg::ADDR_FLAGS, 32'h102);
        rv = '0;
        rv.valid = 1'b1;
        rv.length = 4'h2;
        ret(rv);
        seen = status.step_trap;
        repeat (2) begin
            @(posedge pclk);
            #1;
            seen = seen | status.step_trap;
        end
        chk(32'(seen), 32'h1);
        chk(32'(processor_status_flags[8]), 32'h0);
        rv.redirect = 1'b1;
        rv.target = 32'h1234;
        ret(rv);
        chk(next_instr_pointer, 32'h1234);
        apb(1'b1, 12'h010, 32'hffffffff);
        chk(32'(er), 32'h1);
        apb(1'b0, 12'h010, '0);
        chk(rd, 32'h0);
        $display("end of register tests");
        for (int k = 0; k < 12; k++) begin
            @(posedge pclk);
            seg_req <= '{fss_pkg::fss_ref_t'(k / 2), k[0], fss_pkg::fss_seg_t'(k % 6)};
            #1;
            case (k / 2)
                0: e = fss_pkg::FSS_SEG_CS;
                1, 2: e = fss_pkg::FSS_SEG_SS;
                3: e = fss_pkg::FSS_SEG_ES;
                4: e = k[0] ? fss_pkg::fss_seg_t'(k % 6) : fss_pkg::FSS_SEG_DS;
                default: e = k[0] ? fss_pkg::fss_seg_t'(k % 6) : fss_pkg::FSS_SEG_SS;
            endcase
            chk(32'(seg_sel), 32'(e));
        end
        $display("end of segment tests");
        apb(1'b1, fss_pkg::ADDR_CTRL, 32'h31);
        apb(1'b1, fss_pkg::ADDR_FLAGS, 32'h4000);
        io_access <= 1'b1;
        @(posedge pclk);
        #1;
        chk(32'({status.nested, status.io_fault, gp_fault}), 32'h7);
        rv = '0;
        rv.valid = 1'b1;
        rv.popf = 1'b1;
        rv.new_flags = 32'h0002_0200;
        ret(rv);
        chk(processor_status_flags, 32'h2);
        rv.popf = 1'b0;
        rv.task_sw = 1'b1;
        ret(rv);
        io_access <= 1'b0;
        priv_opcode <= 1'b1;
        @(posedge pclk);
        #1;
        chk(32'({status.v86, gp_fault}), 32'h3);
        apb(1'b1, fss_pkg::ADDR_FLAGS, 32'h1_0000);
        #1;
        chk(32'(debug_fault), 32'h0);
        rv = '0;
        rv.valid = 1'b1;
        ret(rv);
        chk(32'(debug_fault), 32'h1);
        $display("end of mode tests");
        results();
    end
endmodule : tb_top
`default_nettype wire
